/* File: tnb_pkg.sv */
/*
  Shared constants and types for the token network buffer sequencer.
  Assumes both ends run on one pclk and meet through tnb_if.
*/
package tnb_pkg;
  // ****************************************************
  // Buffer geometry
  // ****************************************************
  localparam int unsigned AW          = 11;
  localparam int unsigned BUF_DEPTH   = 2048;
  localparam logic [10:0] PAGE_BYTES  = 11'h0200;
  localparam logic [10:0] HALF_BYTES  = 11'h0100;
  localparam logic [10:0] ADDR_SRC    = 11'h0000;
  localparam logic [10:0] ADDR_DST    = 11'h0001;
  localparam logic [10:0] ADDR_CNT    = 11'h0002;
  localparam logic [10:0] ADDR_LCNT   = 11'h0003;
  localparam logic [9:0]  SHORT_BASE  = 10'h0100;
  localparam logic [9:0]  LONG_BASE   = 10'h0200;
  // ****************************************************
  // Host-side register indices
  // ****************************************************
  localparam logic [2:0] REG_STATUS   = 3'h0;
  localparam logic [2:0] REG_COMMAND  = 3'h1;
  localparam logic [2:0] REG_PTR_HI   = 3'h2;
  localparam logic [2:0] REG_PTR_LO   = 3'h3;
  localparam logic [2:0] REG_DATA     = 3'h4;
  localparam logic [2:0] REG_MASK     = 3'h5;
  localparam logic [2:0] REG_CONFIG   = 3'h6;
  localparam logic [2:0] REG_NODE     = 3'h7;
  // Field positions
  localparam int unsigned PTR_AUTOINC = 7;
  localparam int unsigned CMD_OFFSET  = 5;
  localparam int unsigned ST_TXA      = 0;
  localparam int unsigned ST_TMA      = 1;
  localparam int unsigned ST_RXI      = 2;
  localparam int unsigned ST_XNAK     = 3;
  localparam int unsigned CFG_LONG    = 0;
  // Command codes (low three bits / full byte pattern)
  localparam logic [7:0] CMD_DIS_TX   = 8'h01;
  localparam logic [7:0] CMD_DIS_RX   = 8'h02;
  localparam logic [2:0] CMD_EN_TX    = 3'h3;
  localparam logic [2:0] CMD_EN_RX    = 3'h4;
  localparam logic [7:0] NAK_LIMIT    = 8'h80;
  // ****************************************************
  // Link handshake codes
  // ****************************************************
  typedef enum logic [2:0] {
    TNB_RSP_NONE  = 3'h0,
    TNB_RSP_ACK   = 3'h1,
    TNB_RSP_NAK   = 3'h2,
    TNB_RSP_NOISE = 3'h3
  } tnb_rsp_e;

  // Start address of a page: page*512 + offset*256
  function automatic logic [10:0] tnb_page_base(input logic [1:0] pg, input logic off);
    tnb_page_base = 11'({pg, 9'h000}) + (off ? HALF_BYTES : 11'h000);
  endfunction : tnb_page_base
endpackage : tnb_pkg

/* File: tnb_if.sv */
/*
  Link between the device end and the host end.
  Assumes one pclk; ports are plain synchronous levels and pulses.
*/
`timescale 1ns/100ps
interface tnb_if (input wire logic pclk);
  logic       reg_wr;   // One-cycle register write strobe
  logic       reg_rd;   // One-cycle register read strobe
  logic [2:0] reg_idx;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       irq;

  modport dev  (input reg_wr, reg_rd, reg_idx, reg_wdata, output reg_rdata, irq);
  modport host (output reg_wr, reg_rd, reg_idx, reg_wdata, input reg_rdata, irq);
endinterface : tnb_if

/* File: tnb_device.sv */
/*
  Device end: 2K buffer, pointer access, transmit and receive sequencing.
  Assumes a network-side peer drives token and response levels on pclk.
*/
// The register addresses and the APB register port are this design's own decisions.
// Operation
// - Pointer high then low; low loads address
// - Auto-increment advances and prefetches next byte
// - Four 512-byte pages chosen by page field
// - Offset bit five adds 256 bytes
// - 0010_0011 is transmit from page0 upper half
// - Start address is page*512 plus offset*256
// - No page boundary check during reception
// - Long if byte2 zero, count from byte3
// - Byte0 source, byte1 destination; tx writes node
// - Software keeps lengths within short/long ranges
// - Enable transmit clears available and acknowledge
// - Non-broadcast sends free buffer enquiry first
// - Enquiry ACK: send; packet ACK sets both
// - Enquiry NAK: pass token, retry next time
// - Answer enquiry NAK while receiver inhibited
// - Excessive NAK flag set, may interrupt
// - Disable transmit abandons at next token
// - No enquiry response: available set, ack clear
// - Noise response: token held, not passed
// - Transmit conclusion interrupts when mask allows
// - Enable receive clears inhibit, selects page
// - Stored packet sets inhibit, may interrupt
// - Received bytes stored in sender layout
`timescale 1ns/100ps
module tnb_device
  import tnb_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Host side
  tnb_if.dev              hif,
  // Network side: token and enquiry answer
  input  wire logic       net_token,
  input  wire logic [2:0] net_fbe_rsp,
  input  wire logic       net_pkt_ack,
  // Network side: receive byte stream
  input  wire logic       net_rx_valid,
  input  wire logic [7:0] net_rx_byte,
  input  wire logic       net_rx_end,
  input  wire logic       net_fbe_in,
  // Network side: transmit outputs
  output logic            net_fbe_out,
  output logic            net_fbe_nak,
  output logic            net_tx_valid,
  output logic [7:0]      net_tx_byte,
  output logic            net_tx_last,
  output logic            net_pass_token
);
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_WAIT = 5'b00010,
    TX_FBE  = 5'b00100,
    TX_HDR  = 5'b01000,
    TX_SEND = 5'b10000
  } tnb_tx_e;

  typedef struct packed {
    logic [10:0] ptr;
    logic        autoinc;
    logic [2:0]  ptr_hi;
    logic [7:0]  data;
    logic        txa, tx_msg_acked_flag, rxi, xnak;
    logic [3:0]  mask;
    logic [7:0]  cfg;
    logic [7:0]  node;
    tnb_tx_e     tx;
    logic        dis_pend, tok_wait;
    logic [10:0] tx_base, rx_base;
    logic [10:0] tx_addr, rx_addr;
    logic [9:0]  remain;
    logic [7:0]  nak_cnt;
    logic        fbe_out, fbe_nak, tv, tl, pass;
    logic [7:0]  tb;
    logic [7:0]  rdata;
    logic        irq;
  } tnb_dev_s;

  tnb_dev_s q, d;
  logic [7:0] mem [BUF_DEPTH];
  logic       mem_we;
  logic [10:0] mem_wa;
  logic [7:0] mem_wd;

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    logic [7:0] c2;
    logic [7:0] c3;
    d      = q;
    c2     = mem[q.tx_base + ADDR_CNT];
    c3     = mem[q.tx_base + ADDR_LCNT];
    mem_we = 1'b0;
    mem_wa = q.ptr;
    mem_wd = hif.reg_wdata;
    d.fbe_out = 1'b0;
    d.fbe_nak = 1'b0;
    d.tv      = 1'b0;
    d.tl      = 1'b0;
    d.pass    = 1'b0;
    // Host register writes
    if (hif.reg_wr) begin
      unique case (hif.reg_idx)
        REG_PTR_HI: begin
          d.autoinc = hif.reg_wdata[PTR_AUTOINC];
          d.ptr_hi  = hif.reg_wdata[2:0];
        end
        REG_PTR_LO: begin
          d.ptr  = {q.ptr_hi, hif.reg_wdata};
          d.data = mem[{q.ptr_hi, hif.reg_wdata}];
        end
        REG_DATA: begin
          mem_we = 1'b1;
          if (q.autoinc) begin
            d.ptr  = q.ptr + 11'h001;
            d.data = mem[q.ptr + 11'h001];
          end
        end
        REG_MASK:   d.mask = hif.reg_wdata[3:0];
        REG_CONFIG: d.cfg  = hif.reg_wdata;
        REG_NODE:   d.node = hif.reg_wdata;
        REG_COMMAND: begin
          if (hif.reg_wdata == CMD_DIS_TX) begin
            d.dis_pend = 1'b1;
          end else if (hif.reg_wdata[2:0] == CMD_EN_TX && q.txa) begin
            // Page and offset fields decode as for 0010_0011
            d.tx_base  = tnb_page_base(hif.reg_wdata[4:3],
                                       hif.reg_wdata[CMD_OFFSET]);
            d.txa      = 1'b0;
            d.tx_msg_acked_flag      = 1'b0;
            d.tx       = TX_WAIT;
            d.nak_cnt  = 8'h00;
            d.dis_pend = 1'b0;
            d.tok_wait = 1'b0;
          end else if (hif.reg_wdata[2:0] == CMD_EN_RX) begin
            d.rx_base = tnb_page_base(hif.reg_wdata[4:3],
                                      hif.reg_wdata[CMD_OFFSET]);
            d.rx_addr = tnb_page_base(hif.reg_wdata[4:3],
                                      hif.reg_wdata[CMD_OFFSET]);
            d.rxi     = 1'b0;
          end else if (hif.reg_wdata == CMD_DIS_RX) begin
            d.rxi = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Data register read prefetches next byte
    if (hif.reg_rd && hif.reg_idx == REG_DATA && q.autoinc) begin
      d.ptr  = q.ptr + 11'h001;
      d.data = mem[q.ptr + 11'h001];
    end
    // Transmit sequencer
    unique case (q.tx)
      TX_IDLE: ;
      TX_WAIT: begin
        if (q.tok_wait) begin
          // Token was passed on; retry only once it has left and come back
          d.tok_wait = net_token;
        end else if (net_token) begin
          if (q.dis_pend) begin
            d.txa = 1'b1;
            d.tx  = TX_IDLE;
          end else if (mem[q.tx_base + ADDR_DST] == 8'h00) begin
            d.tx  = TX_HDR;                                    // broadcast skips enquiry
          end else begin
            d.fbe_out = 1'b1;
            d.tx      = TX_FBE;
          end
        end
      end
      TX_FBE: begin
        unique case (net_fbe_rsp)
          TNB_RSP_ACK: d.tx = TX_HDR;
          TNB_RSP_NAK: begin
            d.pass    = 1'b1;
            d.tok_wait = 1'b1;
            d.tx      = TX_WAIT;
            d.nak_cnt = q.nak_cnt + 8'h01;
            if (q.nak_cnt + 8'h01 == NAK_LIMIT) d.xnak = 1'b1;
          end
          TNB_RSP_NOISE: d.tx = TX_IDLE;
          default: begin
            d.txa = 1'b1;
            d.tx  = TX_IDLE;
          end
        endcase
      end
      TX_HDR: begin
        // Long when byte2 is zero and long mode on
        if (q.cfg[CFG_LONG] && c2 == 8'h00) begin
          d.tx_addr = q.tx_base + 11'({2'b00, c3});
          d.remain  = LONG_BASE - {2'b00, c3};
        end else begin
          d.tx_addr = q.tx_base + 11'({3'b000, c2});
          d.remain  = SHORT_BASE - {2'b00, c2};
        end
        d.tv = 1'b1;
        d.tb = q.node;
        d.tx = TX_SEND;
      end
      TX_SEND: begin
        d.tv      = 1'b1;
        d.tb      = mem[q.tx_addr];
        d.tx_addr = q.tx_addr + 11'h001;
        d.remain  = q.remain - 10'h001;
        if (q.remain == 10'h001) begin
          d.tl  = 1'b1;
          d.txa = 1'b1;
          d.tx_msg_acked_flag = net_pkt_ack;
          d.tx  = TX_IDLE;
        end
      end
      default: d.tx = TX_IDLE;
    endcase
    // Enquiry answers and reception
    d.fbe_nak = net_fbe_in & q.rxi;
    if (net_rx_valid && !q.rxi && !mem_we) begin
      mem_we = 1'b1;
      mem_wa = q.rx_addr;
      mem_wd = net_rx_byte;
      d.rx_addr = q.rx_addr + 11'h001;
    end
    if (net_rx_end && !q.rxi) d.rxi = 1'b1;
    // Register read value and interrupt
    unique case (hif.reg_idx)
      REG_STATUS: d.rdata = {4'h0, q.xnak, q.rxi, q.tx_msg_acked_flag, q.txa};
      REG_PTR_HI: d.rdata = {q.autoinc, 4'h0, q.ptr[10:8]};
      REG_PTR_LO: d.rdata = q.ptr[7:0];
      REG_DATA:   d.rdata = q.data;
      default:    d.rdata = 8'h00;
    endcase
    d.irq = (q.txa & q.mask[ST_TXA]) | (q.rxi & q.mask[ST_RXI])
          | (q.xnak & q.mask[ST_XNAK]);
  end

  // ****************************************************
  // Registers and buffer
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q     <= '0;
      q.tx  <= TX_IDLE;
      q.txa <= 1'b1;
      q.rxi <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge pclk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  assign hif.reg_rdata   = q.rdata;
  assign hif.irq         = q.irq;
  assign net_fbe_out     = q.fbe_out;
  assign net_fbe_nak     = q.fbe_nak;
  assign net_tx_valid    = q.tv;
  assign net_tx_byte     = q.tb;
  assign net_tx_last     = q.tl;
  assign net_pass_token  = q.pass;
endmodule : tnb_device

/* File: tnb_host.sv */
/*
  Host end: APB slave turning register orders into device accesses.
  Assumes the device answers reads one cycle after a strobe.
*/
`timescale 1ns/100ps
module tnb_host
  import tnb_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [4:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_out,
  // Device side
  tnb_if.host              dif
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_WAIT = 3'b010,
    HS_DONE = 3'b100
  } tnb_hs_e;

  typedef struct packed {
    tnb_hs_e     st;
    logic        wr, rd;
    logic [2:0]  idx;
    logic [7:0]  wd;
    logic [31:0] rdata;
    logic        ready, irq;
  } tnb_host_s;

  tnb_host_s q, d;

  // ****************************************************
  // APB handshake: strobe, wait one cycle, answer
  // ****************************************************
  always_comb begin
    d       = q;
    d.wr    = 1'b0;
    d.rd    = 1'b0;
    d.ready = 1'b0;
    d.irq   = dif.irq;
    unique case (q.st)
      HS_IDLE: if (psel && !penable) begin
        d.idx = paddr[4:2];
        d.wd  = pwdata[7:0];
        d.wr  = pwrite;
        d.rd  = !pwrite;
        d.st  = HS_WAIT;
      end
      HS_WAIT: d.st = HS_DONE;
      HS_DONE: begin
        // Device read data stands one cycle after its strobe, not during it
        d.rdata = {24'h00_0000, dif.reg_rdata};
        d.ready = 1'b1;
        d.st    = HS_IDLE;
      end
      default: d.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q    <= '0;
      q.st <= HS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign dif.reg_wr    = q.wr;
  assign dif.reg_rd    = q.rd;
  assign dif.reg_idx   = q.idx;
  assign dif.reg_wdata = q.wd;
  assign prdata        = q.rdata;
  assign pready        = q.ready;
  assign pslverr       = 1'b0;
  assign irq_out       = q.irq;
endmodule : tnb_host

/* File: tnb_link_checker.sv */
/*
  Link checker: watches the strobes, read data and irq between the ends.
  Assumes tb_top places it beside tnb_if; one pclk, presetn async low.
*/
`timescale 1ns/100ps
module tnb_link_checker
  import tnb_pkg::*;
(
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Link signals
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq
);
  typedef struct packed {
    logic [10:0] ptr;
    logic [2:0]  hi;
    logic        inc;
    logic [7:0]  mask;
    logic        cmd;
  } tnb_chk_s;

  tnb_chk_s st_q;
  tnb_chk_s st_d;

  // ****************************************************
  // Shadow state
  // ****************************************************
  // Pointer, mask and command history as the host wrote them
  always_comb begin
    st_d = st_q;
    if (reg_wr && reg_idx == REG_PTR_HI) begin
      st_d.inc = reg_wdata[PTR_AUTOINC];
      st_d.hi  = reg_wdata[2:0];
    end
    // High byte is only held; the low byte write loads the address
    if (reg_wr && reg_idx == REG_PTR_LO) begin
      st_d.ptr = {st_q.hi, reg_wdata};
    end
    // Only data accesses move the pointer, and only with auto-increment
    if ((reg_wr || reg_rd) && reg_idx == REG_DATA && st_q.inc) begin
      st_d.ptr = st_q.ptr + 11'h001;
    end
    if (reg_wr && reg_idx == REG_MASK) begin
      st_d.mask = reg_wdata;
    end
    if (reg_wr && reg_idx == REG_COMMAND) begin
      st_d.cmd = 1'b1;
    end
  end

  // Register the shadow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_excl_a: assert property (!(reg_wr && reg_rd))
    else $error("read and write strobes overlap");
  wr_pulse_a: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  strobe_gap_a: assert property ((reg_wr || reg_rd) |=> !(reg_wr || reg_rd) [*2])
    else $error("strobes closer than one transfer");
  reset_quiet_a: assert property ($rose(presetn) |-> !irq && !reg_wr && !reg_rd)
    else $error("link active at reset release");
  ptr_lo_a: assert property (reg_rd && reg_idx == REG_PTR_LO |=> reg_rdata == st_q.ptr[7:0])
    else $error("pointer low byte does not show transfers");
  ptr_hi_a: assert property (reg_rd && reg_idx == REG_PTR_HI |=>
    reg_rdata[2:0] == st_q.ptr[10:8] && reg_rdata[7] == st_q.inc)
    else $error("pointer high byte wrong");
  mask_off_a: assert property (st_q.mask == 8'h00 && $past(st_q.mask) == 8'h00 |-> !irq)
    else $error("irq with every source masked");
  reset_status_a: assert property (reg_rd && reg_idx == REG_STATUS && !st_q.cmd |=>
    reg_rdata[ST_TXA] && reg_rdata[ST_RXI])
    else $error("idle status lost before any command");
endmodule : tnb_link_checker

/* File: tb_top.sv */
/*
  Testbench: APB orders to the host end, network stimulus to the device end.
  Assumes tnb_pkg, tnb_if, both ends and tnb_link_checker compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp=%h got=%h", nm, e, g); end end
module tb_top;
  import tnb_pkg::*;
  // Clock, reset and APB
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_out;
  logic [4:0]  paddr;
  logic [31:0] pwdata, prdata, st;
  // Network side
  logic        net_token, net_pkt_ack, net_rx_valid, net_rx_end, net_fbe_in;
  logic [2:0]  net_fbe_rsp;
  logic [7:0]  net_rx_byte, net_tx_byte, first_tx;
  logic        net_fbe_out, net_fbe_nak, net_tx_valid, net_tx_last, net_pass_token;
  // Bench state
  logic        tok_run, fbe_late;
  logic [3:0]  tcnt;
  logic [7:0]  rx_pkt [4] = '{8'h33, 8'h12, 8'hFF, 8'hA5};
  int          fail_count, cmp_count, n_fbe, n_pass, n_nak, n_tx, n_last;

  tnb_if link_if (.pclk(pclk));
  tnb_device tnb_device_inst (.pclk(pclk), .presetn(presetn), .hif(link_if),
    .net_token(net_token), .net_fbe_rsp(net_fbe_rsp), .net_pkt_ack(net_pkt_ack),
    .net_rx_valid(net_rx_valid), .net_rx_byte(net_rx_byte), .net_rx_end(net_rx_end),
    .net_fbe_in(net_fbe_in), .net_fbe_out(net_fbe_out), .net_fbe_nak(net_fbe_nak),
    .net_tx_valid(net_tx_valid), .net_tx_byte(net_tx_byte), .net_tx_last(net_tx_last),
    .net_pass_token(net_pass_token));
  tnb_host tnb_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_out(irq_out), .dif(link_if));
  tnb_link_checker tnb_link_checker_inst (.pclk(pclk), .presetn(presetn),
    .reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd), .reg_idx(link_if.reg_idx),
    .reg_wdata(link_if.reg_wdata), .reg_rdata(link_if.reg_rdata), .irq(link_if.irq));

  // ****************************************************
  // Clock, token and monitor
  // ****************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Token is present 8 cycles then absent 8 cycles so retries get a chance
  always @(posedge pclk) begin
    tcnt <= tok_run ? tcnt + 4'h1 : 4'h0;
    net_token <= tok_run && !tcnt[3];
  end

  // Count what the device puts on the network
  always @(posedge pclk) begin
    if (net_fbe_out === 1'b1) n_fbe++;
    if (net_pass_token === 1'b1) n_pass++;
    if (net_fbe_nak === 1'b1) n_nak++;
    if (net_tx_valid === 1'b1) begin
      if (n_tx == 0) first_tx = net_tx_byte;
      if (net_tx_last === 1'b1) n_last = n_tx + 1;
      if (n_fbe == 0) fbe_late = 1'b1;
      n_tx++;
    end
  end

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // One APB transfer; an idle edge first keeps psel from being set twice at once
  task automatic apb(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    st = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      summarize();
    end
  endtask : apb

  task automatic rd_chk(input logic [2:0] idx, input logic [31:0] e, input string nm);
    apb(1'b0, idx, 8'h00);
    `CHK(nm, e, st)
  endtask : rd_chk

  task automatic set_ptr(input logic [10:0] a);
    apb(1'b1, REG_PTR_HI, {1'b1, 4'h0, a[10:8]});
    apb(1'b1, REG_PTR_LO, a[7:0]);
  endtask : set_ptr

  // Poll status until the masked bits match, bounded
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 8'h00);
      k++;
    end while ((st & m) !== v && k < 1000);
    `CHK("status", v, st & m)
    if (k >= 1000) summarize();
  endtask : wait_st

  task automatic irq_chk(input logic [7:0] m, input logic e);
    apb(1'b1, REG_MASK, m);
    repeat (4) @(posedge pclk);
    `CHK("irq", e, irq_out)
  endtask : irq_chk

  task automatic clr();
    n_fbe = 0;
    n_pass = 0;
    n_nak = 0;
    n_tx = 0;
    n_last = 0;
    fbe_late = 1'b0;
  endtask : clr

  // ****************************************************
  // Sequence
  // ****************************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tok_run, tcnt} = '0;
    {net_token, net_pkt_ack, net_rx_valid, net_rx_end, net_fbe_in} = '0;
    net_fbe_rsp = TNB_RSP_NONE;
    net_rx_byte = 8'h00;
    fail_count = 0;
    cmp_count = 0;
    clr();
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(REG_STATUS, 32'h0000_0005, "st_reset");
    // Short packet in page 0 upper half: dest, count 256-3, three data bytes
    apb(1'b1, REG_NODE, 8'h12);
    set_ptr(11'h101);
    apb(1'b1, REG_DATA, 8'h05);
    apb(1'b1, REG_DATA, 8'hFD);
    set_ptr(11'h1FD);
    for (int i = 0; i < 3; i++) apb(1'b1, REG_DATA, 8'hC1 + 8'(i));
    rd_chk(REG_PTR_LO, 32'h0000_0000, "ptr_lo");
    rd_chk(REG_PTR_HI, 32'h0000_0082, "ptr_hi");
    set_ptr(11'h1FD);
    for (int i = 0; i < 3; i++) rd_chk(REG_DATA, 32'(8'hC1 + 8'(i)), "data");
    // Enquiry and packet both acknowledged
    net_fbe_rsp <= TNB_RSP_ACK;
    net_pkt_ack <= 1'b1;
    apb(1'b1, REG_COMMAND, 8'h23);
    rd_chk(REG_STATUS, 32'h0000_0004, "st_txgo");
    clr();
    tok_run <= 1'b1;
    wait_st(32'h0000_000F, 32'h0000_0007);
    tok_run <= 1'b0;
    `CHK("fbe_first", 1'b0, fbe_late)
    `CHK("src_byte", 8'h12, first_tx)
    `CHK("short_last", 4, n_last)
    irq_chk(8'h01, 1'b1);
    irq_chk(8'h00, 1'b0);
    // Long packet from page 1: byte2 zero, byte3 holds 512-257
    apb(1'b1, REG_CONFIG, 8'h01);
    set_ptr(11'h201);
    apb(1'b1, REG_DATA, 8'h05);
    apb(1'b1, REG_DATA, 8'h00);
    apb(1'b1, REG_DATA, 8'hFF);
    apb(1'b1, REG_COMMAND, 8'h0B);
    clr();
    tok_run <= 1'b1;
    wait_st(32'h0000_0003, 32'h0000_0003);
    tok_run <= 1'b0;
    `CHK("long_last", 258, n_last)
    // Enquiry refused on every token until the limit trips
    net_fbe_rsp <= TNB_RSP_NAK;
    apb(1'b1, REG_COMMAND, 8'h23);
    clr();
    tok_run <= 1'b1;
    wait_st(32'h0000_000B, 32'h0000_0008);
    `CHK("nak_retry", 1'b1, n_fbe > 1 && n_pass > 0)
    irq_chk(8'h08, 1'b1);
    irq_chk(8'h00, 1'b0);
    apb(1'b1, REG_COMMAND, CMD_DIS_TX);
    wait_st(32'h0000_0003, 32'h0000_0001);
    // No answer at all to the enquiry
    net_fbe_rsp <= TNB_RSP_NONE;
    apb(1'b1, REG_COMMAND, 8'h23);
    wait_st(32'h0000_0003, 32'h0000_0001);
    tok_run <= 1'b0;
    // Inhibited receiver refuses, then takes a packet into page 2
    repeat (20) @(posedge pclk);
    clr();
    net_fbe_in <= 1'b1;
    @(posedge pclk);
    net_fbe_in <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("fbe_nak", 1'b1, n_nak > 0)
    apb(1'b1, REG_COMMAND, 8'h14);
    wait_st(32'h0000_0004, 32'h0000_0000);
    foreach (rx_pkt[i]) begin
      net_rx_valid <= 1'b1;
      net_rx_byte <= rx_pkt[i];
      @(posedge pclk);
    end
    net_rx_valid <= 1'b0;
    net_rx_end <= 1'b1;
    @(posedge pclk);
    net_rx_end <= 1'b0;
    wait_st(32'h0000_0004, 32'h0000_0004);
    set_ptr(11'h400);
    for (int i = 0; i < 3; i++) rd_chk(REG_DATA, 32'(rx_pkt[i]), "rx_buf");
    irq_chk(8'h04, 1'b1);
    irq_chk(8'h00, 1'b0);
    // Noise answer: token is kept, transmitter stays busy
    net_fbe_rsp <= TNB_RSP_NOISE;
    apb(1'b1, REG_COMMAND, 8'h23);
    clr();
    tok_run <= 1'b1;
    repeat (200) @(posedge pclk);
    `CHK("noise_hold", 0, n_pass)
    wait_st(32'h0000_0001, 32'h0000_0000);
    summarize();
  end
endmodule : tb_top
